// file: src/pwm_event_sync.sv
// Per-channel timer events and cross-channel operation enable trigger
`timescale 1ns/1ps
module pwm_event_sync
(
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic [2:0]              ratio_select,
    input  wire logic [3:0]              count_step,
    input  wire logic [3:0]              count_down,
    input  wire logic [3:0][31:0]        channel_counter,
    input  wire logic [3:0][31:0]        period_setting_reg,
    input  wire logic [3:0][31:0]        compare_capture_reg_a,
    input  wire logic [3:0][31:0]        compare_capture_reg_b,
    input  wire logic [3:0][31:0]        compare_reg_c,
    input  wire logic [3:0][31:0]        compare_reg_d,
    input  wire logic [3:0][31:0]        compare_reg_e,
    input  wire logic [3:0][31:0]        compare_reg_f,
    input  wire logic [3:0]              capture_a,
    input  wire logic [3:0]              capture_b,
    input  wire logic [3:0]              period_count_stop,
    input  wire logic [3:0]              channel_secure,
    input  wire logic [3:0]              trigger_write,
    input  wire logic [3:0]              trigger_write_secure,
    input  wire logic [3:0][1:0]         trigger_write_data,
    input  wire logic [3:0][1:0]         sync_enable_select_reg,
    output logic      [3:0][8:0]         irq_event,
    output logic      [3:0][8:0]         dma_request,
    output logic      [3:0]              operation_enable,
    output logic                         core_tick
);
    logic [5:0]      div_count;
    logic [5:0]      next_div_count;
    logic [5:0]      div_limit;
    logic [2:0]      ratio_clamped;
    logic            tick;
    logic            next_core_tick;
    logic [3:0][8:0] next_irq_event;
    logic [3:0]      next_operation_enable;
    logic [3:0]      start_hit;
    logic [3:0]      stop_hit;

    // Core clock divider; a ratio change mid-period keeps the count and ticks at once if the count already meets the new limit
    always_comb
    begin
        ratio_clamped = (ratio_select > pwm_event_pkg::RATIO_SEL_MAX) ?
                        pwm_event_pkg::RATIO_SEL_MAX : ratio_select;
        // At ratio 64 the shift wraps to zero; minus one still gives 63
        div_limit = (pwm_event_pkg::DIV_ONE << ratio_clamped)
                    - pwm_event_pkg::DIV_ONE;
        tick = (div_count >= div_limit);
        next_div_count = tick ? pwm_event_pkg::DIV_RESET
                              : div_count + pwm_event_pkg::DIV_ONE;
        next_core_tick = tick;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_count <= pwm_event_pkg::DIV_RESET;
            core_tick <= 1'b0;
        end
        else
        begin
            div_count <= next_div_count;
            core_tick <= next_core_tick;
        end
    end

    // Event detection, sampled only on core clock ticks
    always_comb
    begin
        logic [31:0] mask;
        logic [31:0] cnt;
        logic        step;
        mask = pwm_event_pkg::WIDE_BITS;
        cnt  = '0;
        step = 1'b0;
        next_irq_event = '0;
        for (int c = 0; c < pwm_event_pkg::NUM_CHANNELS; c++)
        begin
            // Narrow channels compare only their low half
            mask = pwm_event_pkg::WIDE_MASK[c] ? pwm_event_pkg::WIDE_BITS
                                               : pwm_event_pkg::NARROW_BITS;
            cnt  = channel_counter[c] & mask;
            step = tick & count_step[c];
            next_irq_event[c][pwm_event_pkg::EV_CCMP_A] = tick &
                ((step & (cnt == (compare_capture_reg_a[c] & mask)))
                 | capture_a[c]);
            next_irq_event[c][pwm_event_pkg::EV_CCMP_B] = tick &
                ((step & (cnt == (compare_capture_reg_b[c] & mask)))
                 | capture_b[c]);
            next_irq_event[c][pwm_event_pkg::EV_CMP_C] =
                step & (cnt == (compare_reg_c[c] & mask));
            next_irq_event[c][pwm_event_pkg::EV_CMP_D] =
                step & (cnt == (compare_reg_d[c] & mask));
            next_irq_event[c][pwm_event_pkg::EV_CMP_E] =
                step & (cnt == (compare_reg_e[c] & mask));
            next_irq_event[c][pwm_event_pkg::EV_CMP_F] =
                step & (cnt == (compare_reg_f[c] & mask));
            next_irq_event[c][pwm_event_pkg::EV_OVERFLOW] = step &
                ~count_down[c] &
                (cnt == (period_setting_reg[c] & mask));
            next_irq_event[c][pwm_event_pkg::EV_UNDERFLOW] = step &
                count_down[c] & (cnt == '0);
            next_irq_event[c][pwm_event_pkg::EV_PC_STOP] = tick &
                period_count_stop[c] & pwm_event_pkg::PC_STOP_MASK[c];
        end
    end

    // Sampling on ticks keeps each event to one pulse per core cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            irq_event   <= '0;
            dma_request <= '0;
        end
        else
        begin
            irq_event   <= next_irq_event;
            dma_request <= next_irq_event;
        end
    end

    // Simultaneous operation enable across all channels
    always_comb
    begin
        logic writer_ok;
        writer_ok = 1'b0;
        start_hit = '0;
        stop_hit  = '0;
        next_operation_enable = operation_enable;
        for (int c = 0; c < pwm_event_pkg::NUM_CHANNELS; c++)
        begin
            for (int w = 0; w < pwm_event_pkg::NUM_CHANNELS; w++)
            begin
                writer_ok = trigger_write[w] &
                    (trigger_write_secure[w] | ~channel_secure[w]);
                // Accepted non-secure writes still skip secure targets
                if (writer_ok &
                    (trigger_write_secure[w] | ~channel_secure[c]))
                begin
                    start_hit[c] = start_hit[c] |
                        trigger_write_data[w][pwm_event_pkg::TRIG_START];
                    stop_hit[c] = stop_hit[c] |
                        trigger_write_data[w][pwm_event_pkg::TRIG_STOP];
                end
            end
            // Start wins when both arrive together
            if (stop_hit[c] &
                sync_enable_select_reg[c][pwm_event_pkg::TRIG_STOP])
                next_operation_enable[c] = 1'b0;
            if (start_hit[c] &
                sync_enable_select_reg[c][pwm_event_pkg::TRIG_START])
                next_operation_enable[c] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            operation_enable <= pwm_event_pkg::ENABLE_RESET;
        else
            operation_enable <= next_operation_enable;
    end

    // Checks on the event, divider and enable paths
    pc_absent_a: assert property (@(posedge clk_sys) disable iff (reset)
        !irq_event[1][8] && !dma_request[1][8])
        else $error("period stop event on channel without it");

    pc_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
        (tick && period_count_stop[3]) |=> irq_event[3][8])
        else $error("period stop event missed");

    dma_mirror_a: assert property (@(posedge clk_sys) disable iff (reset)
        dma_request == irq_event)
        else $error("dma request differs from event");

    ovf_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
        irq_event[0][6] |-> $past(tick && count_step[0] && !count_down[0]
            && channel_counter[0] == period_setting_reg[0]))
        else $error("overflow without period match");

    udf_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
        (tick && count_step[2] && count_down[2]
         && channel_counter[2][15:0] == 16'h0000) |=> irq_event[2][7])
        else $error("narrow underflow missed");

    cmp_narrow_a: assert property (@(posedge clk_sys) disable iff (reset)
        (tick && count_step[3] && channel_counter[3][15:0]
         == compare_reg_c[3][15:0]) |=> irq_event[3][2])
        else $error("narrow compare c missed");

    tick_spacing_a: assert property (@(posedge clk_sys)
        disable iff (reset)
        (tick && ratio_select == 3'h2 && $past(ratio_select) == 3'h2
         && $past(ratio_select, 2) == 3'h2 && $past(ratio_select, 3) == 3'h2)
        |=> !tick [*3])
        else $error("core tick spacing wrong for ratio four");

    start_load_a: assert property (@(posedge clk_sys)
        disable iff (reset)
        (trigger_write[0] && trigger_write_secure[0]
         && trigger_write_data[0][0] && sync_enable_select_reg[2][0])
        |=> operation_enable[2])
        else $error("selected channel not started");

    stop_load_a: assert property (@(posedge clk_sys)
        disable iff (reset)
        (trigger_write == 4'h1 && trigger_write_secure[0]
         && trigger_write_data[0] == 2'h2 && sync_enable_select_reg[1][1])
        |=> !operation_enable[1])
        else $error("selected channel not stopped");

    secure_hold_a: assert property (@(posedge clk_sys)
        disable iff (reset)
        (channel_secure[2] && (trigger_write & trigger_write_secure) == 4'h0)
        |=> $stable(operation_enable[2]))
        else $error("secure channel changed by non-secure write");

    ns_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
        (trigger_write == 4'h4 && !trigger_write_secure[2]
         && channel_secure[2]) |=> $stable(operation_enable))
        else $error("non-secure write to secure trigger took effect");

    reset_clear_a: assert property (@(posedge clk_sys)
        reset |=> operation_enable == 4'h0 && irq_event == '0)
        else $error("outputs not cleared by reset");
endmodule // pwm_event_sync

// file: src/pwm_event_pkg.sv
// Constants shared by the timer event and simultaneous enable logic
package pwm_event_pkg;
    localparam int          NUM_CHANNELS   = 4;
    localparam int          NUM_EVENTS     = 9;
    localparam int          COUNTER_WIDTH  = 32;
    localparam int          TRIG_WIDTH     = 2;
    localparam int          DIV_WIDTH      = 6;
    // Event positions within a channel's event vector
    localparam int          EV_CCMP_A      = 0;
    localparam int          EV_CCMP_B      = 1;
    localparam int          EV_CMP_C       = 2;
    localparam int          EV_CMP_D       = 3;
    localparam int          EV_CMP_E       = 4;
    localparam int          EV_CMP_F       = 5;
    localparam int          EV_OVERFLOW    = 6;
    localparam int          EV_UNDERFLOW   = 7;
    localparam int          EV_PC_STOP     = 8;
    // Trigger and select bit positions
    localparam int          TRIG_START     = 0;
    localparam int          TRIG_STOP      = 1;
    // Channel index 0..3 stands for channels 1, 2, 4, 5
    localparam logic [3:0]  WIDE_MASK      = 4'h3;
    localparam logic [3:0]  PC_STOP_MASK   = 4'hD;
    localparam logic [31:0] WIDE_BITS      = 32'hFFFFFFFF;
    localparam logic [31:0] NARROW_BITS    = 32'h0000FFFF;
    localparam logic [2:0]  RATIO_SEL_MAX  = 3'h6;
    localparam logic [5:0]  DIV_ONE        = 6'h01;
    localparam logic [5:0]  DIV_RESET      = 6'h00;
    localparam logic [3:0]  ENABLE_RESET   = 4'h0;
endpackage

// file: verification/pwm_event_sink.sv
// Interrupt and DMA controller stand-in that counts timer events
`timescale 1ns/1ps
module pwm_event_sink
(
    input  wire logic            clk_sys,
    input  wire logic            reset,
    input  wire logic [3:0][8:0] irq_event,
    input  wire logic [3:0][8:0] dma_request,
    output int                   pulse_count,
    output int                   path_mismatch
);
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pulse_count   <= 0;
            path_mismatch <= 0;
        end
        else
        begin
            pulse_count <= pulse_count + $countones(irq_event);
            // Both controllers must see every source on the same cycle
            if (dma_request !== irq_event)
                path_mismatch <= path_mismatch + 1;
        end
    end
endmodule // pwm_event_sink

// file: verification/pwm_timer_irq_and_sync_enable_test.sv
// Self-checking bench for timer events and simultaneous enable
`timescale 1ns/1ps
module pwm_timer_irq_and_sync_enable_test;
    logic             clk_sys = 1'b0;
    logic             reset = 1'b1;
    logic [2:0]       ratio_select = 3'h0;
    logic [3:0]       count_step = 4'h0;
    logic [3:0]       count_down = 4'h0;
    logic [3:0][31:0] channel_counter = {4{32'h00000005}};
    logic [3:0][31:0] period_setting_reg = {4{32'h00000100}};
    logic [3:0][31:0] compare_capture_reg_a = {4{32'h00000010}};
    logic [3:0][31:0] compare_capture_reg_b = {4{32'h00000020}};
    logic [3:0][31:0] compare_reg_c = {4{32'h00000030}};
    logic [3:0][31:0] compare_reg_d = {4{32'h00000040}};
    logic [3:0][31:0] compare_reg_e = {4{32'h00000050}};
    logic [3:0][31:0] compare_reg_f = {4{32'h00000060}};
    logic [3:0]       capture_a = 4'h0;
    logic [3:0]       capture_b = 4'h0;
    logic [3:0]       period_count_stop = 4'h0;
    logic [3:0]       channel_secure = 4'h4;
    logic [3:0]       trigger_write = 4'h0;
    logic [3:0]       trigger_write_secure = 4'h0;
    logic [3:0][1:0]  trigger_write_data = '0;
    logic [3:0][1:0]  sync_enable_select_reg = {2'h1, 2'h3, 2'h3, 2'h3};
    logic [3:0][8:0]  irq_event;
    logic [3:0][8:0]  dma_request;
    logic [3:0]       operation_enable;
    logic             core_tick;
    int               pulse_count;
    int               path_mismatch;
    int               n_errors = 0;
    int               samples_checked = 0;

    pwm_event_sync pwm_event_sync_i
    (
        .clk_sys, .reset, .ratio_select, .count_step, .count_down,
        .channel_counter, .period_setting_reg, .compare_capture_reg_a,
        .compare_capture_reg_b, .compare_reg_c, .compare_reg_d,
        .compare_reg_e, .compare_reg_f, .capture_a, .capture_b,
        .period_count_stop, .channel_secure, .trigger_write,
        .trigger_write_secure, .trigger_write_data,
        .sync_enable_select_reg, .irq_event, .dma_request,
        .operation_enable, .core_tick
    );

    pwm_event_sink pwm_event_sink_i
    (
        .clk_sys, .reset, .irq_event, .dma_request, .pulse_count,
        .path_mismatch
    );

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One tick of stimulus, then the pulse must be gone a cycle later
    task automatic ev(input logic [31:0] cnt, input logic dn,
        input logic [3:0] ca, input logic [3:0] cb, input logic [3:0] pcs,
        input logic [3:0][8:0] exp);
        int p0;
        p0 = pulse_count;
        channel_counter = {4{cnt}};
        count_down = {4{dn}};
        capture_a = ca;
        capture_b = cb;
        period_count_stop = pcs;
        count_step = 4'hF;
        @(negedge clk_sys);
        check(irq_event, exp);
        check(dma_request, exp);
        channel_counter = {4{32'h00000005}};
        count_down = 4'h0;
        {capture_a, capture_b, period_count_stop, count_step} = '0;
        @(negedge clk_sys);
        check(irq_event, '0);
        check(36'(pulse_count - p0), 36'($countones(exp)));
    endtask

    // Held capture must pulse once per core tick at every ratio
    task automatic divider();
        int ticks;
        int hits;
        for (int s = 0; s < 8; s++)
        begin
            ratio_select = 3'(s);
            capture_a = 4'h1;
            repeat (80) @(negedge clk_sys);
            ticks = 0;
            hits = 0;
            repeat (128)
            begin
                @(negedge clk_sys);
                ticks += int'(core_tick === 1'b1);
                hits += int'(irq_event[0][0] === 1'b1);
            end
            check(36'(ticks), 36'(128 >> (s > 6 ? 6 : s)));
            check(36'(hits), 36'(128 >> (s > 6 ? 6 : s)));
        end
        ratio_select = 3'h0;
        capture_a = 4'h0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic trig(input int w, input logic sec, input logic [1:0] d,
        input logic [3:0] e);
        trigger_write[w] = 1'b1;
        trigger_write_secure[w] = sec;
        trigger_write_data[w] = d;
        @(negedge clk_sys);
        check(36'(operation_enable), 36'(e));
        {trigger_write, trigger_write_secure, trigger_write_data} = '0;
        @(negedge clk_sys);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        for (int i = 0; i < 6; i++)
            ev(32'h10 * (i + 1), 0, 0, 0, 0, {4{9'h001 << i}});
        ev(32'h100, 0, 0, 0, 0, {4{9'h040}});
        ev(32'h100, 1, 0, 0, 0, '0);
        ev(32'h0, 1, 0, 0, 0, {4{9'h080}});
        ev(32'hABCD0010, 0, 0, 0, 0, {9'h1, 9'h1, 9'h0, 9'h0});
        ev(32'h5, 0, 4'h5, 4'hA, 0, {9'h2, 9'h1, 9'h2, 9'h1});
        ev(32'h5, 0, 0, 0, 4'hF, {9'h100, 9'h100, 9'h0, 9'h100});
        $display("test events done");
        divider();
        $display("test divider done");
        trig(2, 0, 2'h1, 4'h0);
        trig(0, 1, 2'h1, 4'hF);
        trig(1, 0, 2'h2, 4'hC);
        trig(3, 0, 2'h3, 4'hF);
        trig(2, 1, 2'h2, 4'h8);
        trig(0, 1, 2'h0, 4'h8);
        trig(0, 1, 2'h1, 4'hF);
        trig(0, 1, 2'h2, 4'h8);
        $display("test trigger done");
        check(36'(path_mismatch), 36'h0);
        conclude();
    end
endmodule // pwm_timer_irq_and_sync_enable_test
